// >>> verilog/pulse_gate_delay.sv
// module: gate stretch, sync marker, classification and delay channel
// Notes on behaviour
// [RL1] external clock is the fastest rate; slower ranges divide it down
// [RL2] range picks one of five sample rates for the processing path
// [RL3] gate stretch in five doubling steps above position zero
// [RL4] stretch only extends the trailing edge; leading edge unchanged
// [RL5] sync marker of 100 ns at each output pulse leading edge
// [RL6] filter mode filters the spectrum, bypass passes it unfiltered
// [RL7] four averages per transform: 4, 16, 64 and 256 coefficients
// [RL8] partial averages are normalized by the 256-coefficient average
// [RL9] low noise flag while full average is below programmed minimum
// [RL10] nine paths; any non-noise path reconstructs a pulse
// [RL11] false alarm setting picks one of two decision variable sets
// [RL12] any path may be forced, but not while the low noise flag is set
// [RL13] 8-bit delay video is registered, copied to monitor, then delayed
// [RL14] delay latency is eight sample clocks more than the filter delay
// [RL15] detection gate delayed 0 to 15 sample clocks by a setting
// [RL16] gating on passes only samples under delayed gate; off passes all
// [RL17] self test injects an over-range pulse ahead of the converter
// [RL18] source keeps skew between the two video inputs within 1.5 us
// [RL19] gate output is one whenever a reconstructed pulse is output
// [RL20] stretch counts 2, 4, 8, 16 or 32 sample clocks
// [RL21] delayed gate and delayed data share the sample-clock domain
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module pulse_gate_delay #(
    parameter int unsigned FILTER_DELAY = 256
) (
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 resetn,
    // external sample clock, taken as synchronous level
    input  wire logic                 extClk,
    // transform summary and spectrum sample
    input  wire logic                 avgValid,
    input  wire pgd_pkg::avg_type     avgIn,
    input  wire logic [15:0]          coefIn,
    input  wire logic [15:0]          coefFiltered,
    // delay channel video
    input  wire logic [7:0]           videoIn,
    // outputs
    output logic [15:0]               spectrumOut,
    output logic [7:0]                testVideo,
    output logic [7:0]                monitorOut,
    output logic [7:0]                dacOut,
    output logic                      outputGate,
    output logic                      syncOut,
    output logic                      sampleEn,
    output logic                      lowNoiseFlag,
    output logic [3:0]                pathSel,
    // axi4-lite slave
    input  wire logic [7:0]           awaddr,
    input  wire logic                 awvalid,
    output logic                      awready,
    input  wire logic [31:0]          wdata,
    input  wire logic [3:0]           wstrb,
    input  wire logic                 wvalid,
    output logic                      wready,
    output logic [1:0]                bresp,
    output logic                      bvalid,
    input  wire logic                 bready,
    input  wire logic [7:0]           araddr,
    input  wire logic                 arvalid,
    output logic                      arready,
    output logic [31:0]               rdata,
    output logic [1:0]                rresp,
    output logic                      rvalid,
    input  wire logic                 rready
);
    pgd_pkg::ctrl_type ctrl_ff;
    logic [2:0]        stretch_ff;
    logic [15:0]       minAvg_ff;
    logic [4:0]        force_ff;       // bit4 enable, [3:0] path
    logic [7:0]        awAddr_ff;
    logic              awHeld_ff;
    logic [31:0]       wData_ff;
    logic [3:0]        wStrb_ff;
    logic              wHeld_ff;

    // merge byte lanes into a register word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (st[i]) r[8*i +: 8] = nw[8*i +: 8];
        return r;
    endfunction

    // pending write merged over the present contents of the ctrl and minAvg registers
    logic [31:0] ctrlMerged;
    logic [31:0] minAvgMerged;
    assign ctrlMerged   = merge({17'h0, ctrl_ff}, wData_ff, wStrb_ff);
    assign minAvgMerged = merge({16'h0, minAvg_ff}, wData_ff, wStrb_ff);

    // write channels may arrive in either order; hold each until both
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            awHeld_ff <= 1'b0;
            wHeld_ff  <= 1'b0;
            awAddr_ff <= 8'h00;
            wData_ff  <= 32'h0000_0000;
            wStrb_ff  <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                awHeld_ff <= 1'b1;
                awAddr_ff <= awaddr;
            end
            if (wvalid && wready) begin
                wHeld_ff <= 1'b1;
                wData_ff <= wdata;
                wStrb_ff <= wstrb;
            end
            if (awHeld_ff && wHeld_ff) begin
                awHeld_ff <= 1'b0;
                wHeld_ff  <= 1'b0;
            end
        end
    end
    assign awready = !awHeld_ff && !bvalid;
    assign wready  = !wHeld_ff && !bvalid;

    logic doWrite;
    assign doWrite = awHeld_ff && wHeld_ff;

    // write response; unmapped addresses answer slverr
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            bvalid <= 1'b0;
            bresp  <= 2'b00;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            bresp  <= (awAddr_ff <= pgd_pkg::ADDR_FORCE &&
                       awAddr_ff[1:0] == 2'b00) ? 2'b00 : 2'b10;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    // writable registers
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ctrl_ff    <= pgd_pkg::ctrl_type'(pgd_pkg::CTRL_RST[14:0]);
            stretch_ff <= 3'h0;
            minAvg_ff  <= pgd_pkg::MINAVG_RST;
            force_ff   <= 5'h00;
        end else if (doWrite) begin
            case (awAddr_ff)
                pgd_pkg::ADDR_CTRL:
                    ctrl_ff <= pgd_pkg::ctrl_type'(ctrlMerged[14:0]);
                pgd_pkg::ADDR_STRETCH: begin
                    // positions above five saturate at five
                    if (wStrb_ff[0])
                        stretch_ff <= (wData_ff[2:0] > 3'h5) ? 3'h5
                                                            : wData_ff[2:0];
                end
                pgd_pkg::ADDR_MINAVG:
                    minAvg_ff <= minAvgMerged[15:0];
                pgd_pkg::ADDR_FORCE:
                    if (wStrb_ff[0]) force_ff <= wData_ff[4:0];
                default: ;
            endcase
        end
    end

    // sample-clock divider: one-cycle enable per sample
    logic [11:0] div_ff;
    logic [11:0] pre_ff;
    logic        extPrev_ff;
    logic        baseTick;
    logic [11:0] divMax;
    always_comb begin
        case (ctrl_ff.range)                                       // RL2
            pgd_pkg::RANGE_A: divMax = pgd_pkg::DIV_A;
            pgd_pkg::RANGE_B: divMax = pgd_pkg::DIV_B;
            pgd_pkg::RANGE_C: divMax = pgd_pkg::DIV_C;
            pgd_pkg::RANGE_D: divMax = pgd_pkg::DIV_D;
            pgd_pkg::RANGE_E: divMax = pgd_pkg::DIV_E;
            default:          divMax = pgd_pkg::DIV_A;
        endcase
    end
    // external clock edge is the fastest rate directly
    assign baseTick = ctrl_ff.sampleClockSource ? (extClk && !extPrev_ff)
                                                : (pre_ff == 12'h001); // RL1
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            extPrev_ff <= 1'b0;
            pre_ff     <= 12'h001;
            div_ff     <= 12'h001;
            sampleEn   <= 1'b0;
        end else begin
            extPrev_ff <= extClk;
            pre_ff <= (pre_ff >= pgd_pkg::INT_PRESCALE) ? 12'h001
                                                         : pre_ff + 12'h001;
            sampleEn <= 1'b0;
            if (baseTick) begin
                if (div_ff >= divMax) begin                        // RL1
                    div_ff   <= 12'h001;
                    sampleEn <= 1'b1;
                end else begin
                    div_ff <= div_ff + 12'h001;
                end
            end
        end
    end

    // sequency filter or bypass
    always_ff @(posedge mclk) begin
        if (!resetn) spectrumOut <= 16'h0000;
        else spectrumOut <= ctrl_ff.sequencyFilterMode ? coefIn
                                                       : coefFiltered; // RL6
    end

    // normalization: partial averages scaled by the bias level (Q8)
    function automatic logic [15:0] norm(input logic [15:0] a,
                                         input logic [15:0] b);
        logic [23:0] q;
        q = (b == 16'h0000) ? 24'hffffff : ({a, 8'h00} / {8'h00, b});
        return (q > 24'h00ffff) ? 16'hffff : q[15:0];
    endfunction

    logic [15:0] n4_ff;
    logic [15:0] n16_ff;
    logic [15:0] n64_ff;
    logic [15:0] a256_ff;
    // averages supplied per transform; 256 average is the bias   // RL7
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            n4_ff <= 16'h0; n16_ff <= 16'h0; n64_ff <= 16'h0;
            a256_ff <= 16'h0; lowNoiseFlag <= 1'b0;
        end else if (avgValid) begin
            n4_ff   <= norm(avgIn.avg4,  avgIn.avg256);              // RL8
            n16_ff  <= norm(avgIn.avg16, avgIn.avg256);              // RL8
            n64_ff  <= norm(avgIn.avg64, avgIn.avg256);              // RL8
            a256_ff <= avgIn.avg256;
            lowNoiseFlag <= (avgIn.avg256 < minAvg_ff);              // RL9
        end
    end

    // two decision sets; narrow/medium/wide low-amplitude limits
    logic [15:0] narrowLowAmpLimit;
    logic [15:0] mediumLowAmpLimit;
    logic [15:0] wideLowAmpLimit;
    assign narrowLowAmpLimit = ctrl_ff.falseAlarmSetting ? 16'h0180 : 16'h0140;
    assign mediumLowAmpLimit = ctrl_ff.falseAlarmSetting ? 16'h0160 : 16'h0130;
    assign wideLowAmpLimit   = ctrl_ff.falseAlarmSetting ? 16'h0140 : 16'h0120;

    logic [3:0] classPath;
    // simple decision tree over the normalized averages          // RL11
    always_comb begin
        classPath = 4'(pgd_pkg::NOISE_PATH);
        if (n4_ff > {narrowLowAmpLimit[14:0], 1'b0})      classPath = 4'h0;
        else if (n4_ff > narrowLowAmpLimit)               classPath = 4'h1;
        else if (n16_ff > {mediumLowAmpLimit[14:0], 1'b0}) classPath = 4'h2;
        else if (n16_ff > mediumLowAmpLimit)              classPath = 4'h3;
        else if (n64_ff > {wideLowAmpLimit[14:0], 1'b0})  classPath = 4'h4;
        else if (n64_ff > wideLowAmpLimit)                classPath = 4'h5;
        else if (n64_ff > n16_ff && n16_ff > n4_ff)       classPath = 4'h6;
        else if (n4_ff > n64_ff && n16_ff > n64_ff)       classPath = 4'h7;
    end

    logic forceOk;
    assign forceOk = force_ff[4] && !lowNoiseFlag &&
                     force_ff[3:0] <= 4'(pgd_pkg::NOISE_PATH);       // RL12

    // path choice per sample; pulse whenever not the noise path
    logic rawGate_ff;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pathSel    <= 4'(pgd_pkg::NOISE_PATH);
            rawGate_ff <= 1'b0;
        end else if (sampleEn) begin
            pathSel    <= forceOk ? force_ff[3:0] : classPath;      // RL12
            rawGate_ff <= (forceOk ? force_ff[3:0] : classPath)
                          != 4'(pgd_pkg::NOISE_PATH);              // RL10
        end
    end

    // stretch: trailing edge only, 2<<(pos-1) sample clocks
    logic [5:0] stretchCnt_ff;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            stretchCnt_ff <= 6'h00;
        end else if (sampleEn) begin
            if (rawGate_ff) begin
                stretchCnt_ff <= (stretch_ff == 3'h0) ? 6'h00
                               : 6'(6'h01 << stretch_ff);           // RL20
            end else if (stretchCnt_ff != 6'h00) begin
                stretchCnt_ff <= stretchCnt_ff - 6'h01;             // RL4
            end
        end
    end
    // leading edge follows raw gate with no added delay          // RL3
    assign outputGate = rawGate_ff || (stretchCnt_ff != 6'h00);     // RL19

    // sync marker: fixed width in mclk cycles from leading edge
    logic gatePrev_ff;
    logic [3:0] syncCnt_ff;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            gatePrev_ff <= 1'b0;
            syncCnt_ff  <= 4'h0;
        end else begin
            gatePrev_ff <= outputGate;
            if (outputGate && !gatePrev_ff)
                syncCnt_ff <= 4'(pgd_pkg::SYNC_CYCLES);             // RL5
            else if (syncCnt_ff != 4'h0)
                syncCnt_ff <= syncCnt_ff - 4'h1;
        end
    end
    assign syncOut = syncCnt_ff != 4'h0;

    // self test pulse replaces video with full scale
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            testVideo  <= 8'h00;
            monitorOut <= 8'h00;
        end else if (sampleEn) begin
            testVideo  <= ctrl_ff.selfTest ? 8'hff : videoIn;      // RL17
            monitorOut <= ctrl_ff.selfTest ? 8'hff : videoIn;      // RL13
        end
    end

    logic [7:0] delayed;
    delay_line #(
        .WIDTH(8),
        .DEPTH(FILTER_DELAY + pgd_pkg::FIFO_EXTRA - 2)               // RL14
    ) u_fifo (
        .mclk(mclk),
        .resetn(resetn),
        .advance(sampleEn),
        .dataIn(testVideo),
        .dataOut(delayed)
    );

    // gate delay line, same sample enable as the data            // RL21
    logic [15:0] gateSr_ff;
    always_ff @(posedge mclk) begin
        if (!resetn) gateSr_ff <= 16'h0000;
        else if (sampleEn) gateSr_ff <= {gateSr_ff[14:0], outputGate};
    end

    always_ff @(posedge mclk) begin
        if (!resetn) dacOut <= 8'h00;
        else if (sampleEn)
            dacOut <= (!ctrl_ff.gateEnable ||
                       gateSr_ff[ctrl_ff.gateDelay]) ? delayed : 8'h00; // RL15 RL16
    end

    // read channel, one-cycle answer
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0;
            rresp  <= 2'b00;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp  <= 2'b00;
            case (araddr)
                pgd_pkg::ADDR_CTRL:    rdata <= {17'h0, ctrl_ff};
                pgd_pkg::ADDR_STRETCH: rdata <= {29'h0, stretch_ff};
                pgd_pkg::ADDR_MINAVG:  rdata <= {16'h0, minAvg_ff};
                pgd_pkg::ADDR_FORCE:   rdata <= {27'h0, force_ff};
                pgd_pkg::ADDR_STATUS:  rdata <= {26'h0, outputGate,
                                                 lowNoiseFlag, pathSel};
                pgd_pkg::ADDR_AVG:     rdata <= {16'h0, a256_ff};
                pgd_pkg::ADDR_NORM:    rdata <= {n16_ff, n4_ff};
                default: begin
                    rdata <= 32'h0;
                    rresp <= 2'b10;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
    assign arready = !rvalid;

    // checks
    AST_LOWNOISE: assert property (@(posedge mclk) disable iff (!resetn)
        avgValid |=> lowNoiseFlag == ($past(avgIn.avg256) < $past(minAvg_ff)))
        else $error("low noise flag wrong"); // RL9
    AST_FORCE_BLOCK: assert property (@(posedge mclk) disable iff (!resetn)
        sampleEn && lowNoiseFlag |=> pathSel == $past(classPath))
        else $error("force honoured"); // RL12
    AST_GATE: assert property (@(posedge mclk) disable iff (!resetn)
        rawGate_ff |-> outputGate) else $error("gate low on pulse"); // RL19
    AST_PULSE: assert property (@(posedge mclk) disable iff (!resetn)
        rawGate_ff == (pathSel != 4'(pgd_pkg::NOISE_PATH)))
        else $error("pulse/path mismatch"); // RL10
    sequence s_rise;
        outputGate && !gatePrev_ff;
    endsequence
    AST_SYNC: assert property (@(posedge mclk) disable iff (!resetn)
        s_rise |=> syncOut [*4] ##1 !syncOut || outputGate && !gatePrev_ff)
        else $error("sync width"); // RL5
    AST_UNGATED: assert property (@(posedge mclk) disable iff (!resetn)
        sampleEn && !ctrl_ff.gateEnable |=> dacOut == $past(delayed))
        else $error("ungated data lost"); // RL16
    AST_GATED: assert property (@(posedge mclk) disable iff (!resetn)
        sampleEn && ctrl_ff.gateEnable && !gateSr_ff[ctrl_ff.gateDelay]
        |=> dacOut == 8'h00) else $error("gating leak"); // RL15
    AST_SELFTEST: assert property (@(posedge mclk) disable iff (!resetn)
        sampleEn && ctrl_ff.selfTest |=> testVideo == 8'hff)
        else $error("self test missing"); // RL17
    AST_SAMPLE: assert property (@(posedge mclk) disable iff (!resetn)
        sampleEn |=> !sampleEn) else $error("sample enable too long"); // RL2
endmodule // pulse_gate_delay

// >>> verilog/pgd_pkg.sv
// package: constants, types and register map for the pulse gate and delay channel
package pgd_pkg;
    // pulse-width ranges, fastest first
    typedef enum logic [2:0] {
        RANGE_A,
        RANGE_B,
        RANGE_C,
        RANGE_D,
        RANGE_E
    } range_type;

    localparam int unsigned CLK_HZ        = 40000000;
    localparam int unsigned EXT_CLK_MAX_HZ = 20000000;
    // sample-clock divide ratios per range, relative to the fastest rate
    localparam logic [11:0] DIV_A = 12'h001;
    localparam logic [11:0] DIV_B = 12'h004;
    localparam logic [11:0] DIV_C = 12'h00a;
    localparam logic [11:0] DIV_D = 12'h064;
    localparam logic [11:0] DIV_E = 12'h3e8;
    // internal oscillator: fastest rate is every second mclk (20 MHz)
    localparam logic [11:0] INT_PRESCALE = 12'h002;

    // sync marker width in ns, and in mclk cycles
    localparam int unsigned SYNC_NS     = 100;
    localparam int unsigned SYNC_CYCLES =
        (SYNC_NS * (CLK_HZ / 1000000) + 999) / 1000;

    localparam int unsigned FIFO_EXTRA  = 8;   // beyond filter delay
    localparam int unsigned GATE_DLY_MAX = 15;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_STRETCH = 8'h04;
    localparam logic [7:0] ADDR_MINAVG  = 8'h08;
    localparam logic [7:0] ADDR_FORCE   = 8'h0c;
    localparam logic [7:0] ADDR_STATUS  = 8'h10;
    localparam logic [7:0] ADDR_AVG     = 8'h14;
    localparam logic [7:0] ADDR_NORM    = 8'h18;

    // reset values
    localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
    localparam logic [15:0] MINAVG_RST = 16'h0010;

    localparam int unsigned NOISE_PATH = 8;

    // control register fields
    typedef struct packed {
        logic [2:0] gateDelayUnused;
        logic       selfTest;
        logic [3:0] gateDelay;
        logic       gateEnable;
        logic       falseAlarmSetting;
        logic       sequencyFilterMode;
        logic       sampleClockSource;
        range_type  range;
    } ctrl_type;

    // one transform summary from the averaging stage
    typedef struct packed {
        logic [15:0] avg4;
        logic [15:0] avg16;
        logic [15:0] avg64;
        logic [15:0] avg256;
    } avg_type;
endpackage

// >>> verilog/delay_line.sv
// module: fixed-length sample delay built from flip-flops
`timescale 1ns/1ps
module delay_line #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 64
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             resetn,
    // stream
    input  wire logic             advance,
    input  wire logic [WIDTH-1:0] dataIn,
    output logic      [WIDTH-1:0] dataOut
);
    logic [WIDTH-1:0]         mem_ff [DEPTH];
    logic [$clog2(DEPTH)-1:0] ptr_ff;

    // circular buffer: read old slot then overwrite it, latency = DEPTH
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ptr_ff  <= '0;
            dataOut <= '0;
        end else if (advance) begin
            dataOut     <= mem_ff[ptr_ff];
            mem_ff[ptr_ff] <= dataIn;
            ptr_ff <= (ptr_ff == $clog2(DEPTH)'(DEPTH - 1)) ? '0 : ptr_ff + 1'b1;
        end
    end
endmodule // delay_line

// >>> sim/video_src.sv
// partner model: video source and external sample clock
`timescale 1ns/1ps
module video_src (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       resetn,
    // sample pacing from the block
    input  wire logic       sampleEn,
    // far-side outputs
    output logic            extClk,
    output logic      [7:0] videoIn
);
    // ramp video from 01 so delayed samples only pass for idle zeros when the 8-bit ramp wraps to 00
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            extClk  <= 1'b0;
            videoIn <= 8'h01;
        end else begin
            extClk <= ~extClk;
            if (sampleEn) begin
                videoIn <= videoIn + 8'h01;
            end
        end
    end
endmodule // video_src

// >>> sim/tb.sv
// testbench: registers, delay gating, classification and sync marker
`timescale 1ns/1ps
module tb;
    logic             mclk = 0, resetn = 0, avgValid = 0, extClk, sampleEn;
    pgd_pkg::avg_type avgIn = '0;
    logic [15:0]      coefIn = 16'h1234, coefFiltered = 16'h5678, spec;
    logic [7:0]       videoIn, awaddr = 0, araddr = 0, tv, mon, dac;
    logic [31:0]      wdata = 0, rdata, d;
    logic [3:0]       wstrb = 4'hf, pathSel;
    logic [1:0]       bresp, rresp, r;
    logic             awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic             rready = 0, awready, wready, bvalid, arready, rvalid;
    logic             gate, syncOut, lowNoiseFlag;
    int               num_errors = 0, tests_run = 0, n, i, k;
    localparam int    FD = 4;   // short filter delay keeps the run brief
    logic [7:0]       ra [4] = '{8'h08, 8'h04, 8'h04, 8'h0c};
    logic [31:0]      rw [4] = '{32'h100, 32'h5, 32'h7, 32'h13};
    logic [31:0]      rx [4] = '{32'h100, 32'h5, 32'h5, 32'h13};

    always #12.5 mclk = ~mclk;

    pulse_gate_delay #(.FILTER_DELAY(FD)) pulse_gate_delay_i (.mclk(mclk),
        .resetn(resetn), .extClk(extClk), .avgValid(avgValid), .avgIn(avgIn),
        .coefIn(coefIn), .coefFiltered(coefFiltered), .videoIn(videoIn),
        .spectrumOut(spec), .testVideo(tv), .monitorOut(mon), .dacOut(dac),
        .outputGate(gate), .syncOut(syncOut), .sampleEn(sampleEn),
        .lowNoiseFlag(lowNoiseFlag), .pathSel(pathSel), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready));
    video_src video_src_i (.mclk(mclk), .resetn(resetn), .sampleEn(sampleEn),
        .extClk(extClk), .videoIn(videoIn));

    // compare and count
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", nm, e, g);
            num_errors++;
        end
    endtask

    // axi4-lite write; each channel released when taken
    task wr(input logic [7:0] a, input logic [31:0] v);
        awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
        for (n = 0; n < 100; n++) begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bvalid) break;
        end
        // bready stays up: dropping it here would clash with the next call
        chk("bresp", 2'b00, (n < 100) ? bresp : 2'bxx);
        if (n == 100) conclude();
    endtask

    // axi4-lite read
    task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
        araddr <= a; arvalid <= 1; rready <= 1;
        for (n = 0; n < 100; n++) begin
            @(posedge mclk);
            if (arvalid && arready) arvalid <= 0;
            if (rvalid) break;
        end
        v = rdata;
        s = (n < 100) ? rresp : 2'bxx;
        if (n == 100) begin
            num_errors++;
            conclude();
        end
    endtask

    // one transform summary pulse
    task avg(input logic [15:0] full);
        // equal nonzero partials normalise to a flat spectrum: noise path only
        avgIn <= {full, full, full, full};
        avgValid <= 1;
        @(posedge mclk);
        avgValid <= 0;
    endtask

    task conclude;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge mclk);
        resetn <= 1;
        @(posedge mclk);
        rd(8'h00, d, r); chk("ctrl rst", pgd_pkg::CTRL_RST, d);
        rd(8'h08, d, r); chk("minavg rst", 32'h10, d);
        chk("path rst", 4'd8, pathSel);
        rd(8'h20, d, r); chk("unmapped", 2'b10, r);
        for (i = 0; i < 4; i++) begin
            wr(ra[i], rw[i]);
            rd(ra[i], d, r); chk("reg", rx[i], d);
        end
        wr(8'h0c, 32'h0); wr(8'h08, 32'h10);
        wr(8'h00, 32'h40);
        repeat (100) @(posedge mclk);
        chk("gated dac", 8'h00, dac);
        wr(8'h00, 32'h0);
        for (n = 0; n < 400 && dac === 8'h00; n++) @(posedge mclk);
        // latency FD+8 samples; the ramp source has moved one sample on
        d = 32'(8'(videoIn - 8'(FD + pgd_pkg::FIFO_EXTRA + 1)));
        chk("ungated dac", d, dac);
        chk("monitor", 8'(videoIn - 8'h01), mon);
        chk("filtered", 16'h5678, spec);
        wr(8'h00, 32'h810);
        for (n = 0; n < 50 && tv !== 8'hff; n++) @(posedge mclk);
        chk("self test", 8'hff, tv);
        chk("bypass", 16'h1234, spec);
        wr(8'h00, 32'h0);
        avg(16'h0008);
        for (n = 0; n < 50 && lowNoiseFlag !== 1'b1; n++) @(posedge mclk);
        chk("low flag", 1'b1, lowNoiseFlag);
        wr(8'h0c, 32'h13); avg(16'h0008);
        repeat (8) @(posedge mclk);
        chk("no force", 4'd8, pathSel);
        avg(16'h0100);
        for (n = 0; n < 50 && gate !== 1'b1; n++) @(posedge mclk);
        chk("clear flag", 1'b0, lowNoiseFlag);
        chk("forced", 4'd3, pathSel);
        chk("gate", 1'b1, gate);
        // the marker loads on the edge that sees the gate rise
        @(posedge mclk);
        chk("sync lead", 1'b1, syncOut);
        for (n = 0; n < 50 && syncOut === 1'b1; n++) @(posedge mclk);
        chk("sync width", pgd_pkg::SYNC_CYCLES, n);
        rd(8'h14, d, r); chk("avg256", 32'h100, d);
        // position five holds the gate 32 samples past the noise decision
        wr(8'h0c, 32'h0);
        k = 0;
        for (n = 0; n < 200 && gate === 1'b1; n++) begin
            if (sampleEn === 1'b1 && pathSel === 4'd8) k++;
            @(posedge mclk);
        end
        chk("stretch", 32, k);
        // external clock, second range: source ticks every 2 mclk
        wr(8'h00, 32'h9);
        repeat (20) @(posedge mclk);
        for (n = 0; n < 50 && sampleEn !== 1'b1; n++) @(posedge mclk);
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (sampleEn !== 1'b1 && k < 50);
        chk("ext rate", 2 * pgd_pkg::DIV_B, k);
        conclude();
    end
endmodule // tb
